// File: core/eks_key_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Sleep or power loss invalidates scratch memory
// - Key feeds protected read/write crypto
// - Key value never returned to host
// - Status query returns nine flag bits
// - Digest/keygen overwrite key from prior key
// - Fresh value or MAC copy replaces key
// - 256-bit key holds nonce or digest
// - Record 4-bit slot index for generated keys
// - Randomness flag: 0 internal, 1 seed only
// - Digest origin flag set by digest command
// - Keygen origin flag set by keygen command
// - Mac forbidden flag blocks MAC-type use
// - Validity flag shows key validity
// - Power, sleep, brownout, watchdog, tamper clear valid
// - Idle entry and exit keep everything
// - Key writers clear valid on real errors
// - MAC check clears unless copy succeeds
// - Status query never touches valid
// - Other commands clear valid except CRC/retry
module eks_key_reg
  import eks_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sleep_entry,
  input wire logic brownout,
  input wire logic watchdog,
  input wire logic tamper,
  input wire logic idle_mode,
  input wire logic cmd_done,
  input wire logic [3:0] cmd,
  input wire logic [1:0] rc,
  input wire logic copy_ok,
  input wire logic [KEY_W-1:0] new_key,
  input wire logic [SLOT_W-1:0] new_slot,
  input wire logic new_seed_only,
  input wire logic new_slot_nomac,
  input wire logic use_req,
  input wire logic use_mac,
  output logic use_grant,
  output logic use_reject,
  output logic [KEY_W-1:0] crypt_key,
  output logic [FLAGS_W-1:0] status_flags
);
  logic [KEY_W-1:0] key_q;
  logic [SLOT_W-1:0] slot_q;
  logic src_q, dig_q, kgen_q, nomac_q, valid_q;
  logic keep_valid;
  wire logic wipe;
  wire logic done_ok;
  wire logic wr_gen;
  wire logic wr_repl;
  wire logic wr_key;

  eks_valid_ctl u_vctl (
    .cmd(cmd),
    .rc(rc),
    .copy_ok(copy_ok),
    .keep_valid(keep_valid)
  );

  // Volatile loss events; idle_mode deliberately not listed so idle retains
  assign wipe = rst || sleep_entry || brownout || watchdog || tamper;
  assign done_ok = cmd_done && rc == RC_OK;
  assign wr_gen = done_ok && (cmd == CMD_DIGEST || cmd == CMD_KEYGEN);
  assign wr_repl = (done_ok && cmd == CMD_FRESH) || (cmd_done && cmd == CMD_MACCHK && copy_ok);
  assign wr_key = wr_gen || wr_repl;

  // Key data; caller computes new_key from crypt_key for gen commands
  always_ff @(posedge clk) begin
    if (rst || sleep_entry) begin
      key_q <= KEY_RST;
    end else if (wr_key) begin
      key_q <= new_key;
    end
  end

  // Metadata; idle changes nothing here
  always_ff @(posedge clk) begin
    if (rst || sleep_entry) begin
      slot_q <= SLOT_RST;
      src_q <= 1'b0;
      dig_q <= 1'b0;
      kgen_q <= 1'b0;
      nomac_q <= 1'b0;
    end else if (wr_gen) begin
      slot_q <= new_slot;
      src_q <= new_seed_only;
      dig_q <= (cmd == CMD_DIGEST);
      kgen_q <= (cmd == CMD_KEYGEN);
      nomac_q <= nomac_q || new_slot_nomac;
    end else if (wr_repl) begin
      slot_q <= SLOT_RST;
      src_q <= new_seed_only;
      dig_q <= 1'b0;
      kgen_q <= 1'b0;
      nomac_q <= new_slot_nomac;
    end
  end

  // Validity flag
  always_ff @(posedge clk) begin
    if (wipe) begin
      valid_q <= 1'b0;
    end else if (wr_key) begin
      valid_q <= 1'b1;
    end else if (cmd_done && !keep_valid) begin
      valid_q <= 1'b0;
    end
  end

  // Key use gating; mac-type uses also need nomac clear
  assign use_grant = use_req && valid_q && !(use_mac && nomac_q);
  assign use_reject = use_req && !use_grant;
  // Key leaves only toward internal crypto, zero when not granted
  assign crypt_key = use_grant ? key_q : KEY_RST;
  assign status_flags = {valid_q, nomac_q, kgen_q, dig_q, src_q, slot_q};

  a_sleep_clears: assert property (@(posedge clk) sleep_entry |=> !valid_q && key_q == KEY_RST)
    else $error("sleep did not wipe key");
  a_tamper_clears: assert property (@(posedge clk) (tamper || watchdog || brownout) |=> !valid_q)
    else $error("loss event kept valid");
  a_status_keeps: assert property (@(posedge clk) disable iff (rst)
    (cmd_done && cmd == CMD_STATUS && !wipe) |=> valid_q == $past(valid_q))
    else $error("status changed valid");
  a_mac_clear: assert property (@(posedge clk) disable iff (rst)
    (cmd_done && cmd == CMD_MACCHK && !copy_ok) |=> !valid_q)
    else $error("mac check kept valid");
  a_other_clear: assert property (@(posedge clk) disable iff (rst)
    (cmd_done && cmd == CMD_USEKEY && rc == RC_OK) |=> !valid_q)
    else $error("other cmd kept valid");
  a_gen_err: assert property (@(posedge clk) disable iff (rst)
    (cmd_done && (cmd == CMD_DIGEST || cmd == CMD_KEYGEN || cmd == CMD_FRESH)
     && rc == RC_ERR) |=> !valid_q)
    else $error("error kept valid");
  a_crc_keep: assert property (@(posedge clk) disable iff (rst)
    (cmd_done && cmd == CMD_USEKEY && (rc == RC_CRC || rc == RC_RETRY) && !wipe)
    |=> valid_q == $past(valid_q))
    else $error("crc dropped valid");
  a_reject_inv: assert property (@(posedge clk) (use_req && !valid_q) |-> use_reject && !use_grant)
    else $error("invalid key granted");
  a_digest_flags: assert property (@(posedge clk) disable iff (rst)
    (wr_gen && cmd == CMD_DIGEST && !wipe) |=> dig_q && !kgen_q && slot_q == $past(new_slot) && valid_q)
    else $error("digest metadata wrong");
  a_idle_keep: assert property (@(posedge clk) disable iff (rst)
    (idle_mode && !cmd_done && !wipe) |=> key_q == $past(key_q) && valid_q == $past(valid_q))
    else $error("idle changed key");
  c_fresh: cover property (@(posedge clk) wr_repl && cmd == CMD_FRESH);
  c_keygen: cover property (@(posedge clk) wr_gen && cmd == CMD_KEYGEN);
  c_mac_reject: cover property (@(posedge clk) use_reject && valid_q);
endmodule // eks_key_reg
`default_nettype wire

// File: inc/eks_pkg.sv
package eks_pkg;
  // Key register width, slot index width and status word width
  localparam int KEY_W = 256;
  localparam int SLOT_W = 4;
  localparam int FLAGS_W = 9;
  // Command codes seen on the command port
  localparam logic [3:0] CMD_FRESH = 4'h1;
  localparam logic [3:0] CMD_DIGEST = 4'h2;
  localparam logic [3:0] CMD_KEYGEN = 4'h3;
  localparam logic [3:0] CMD_MACCHK = 4'h4;
  localparam logic [3:0] CMD_STATUS = 4'h5;
  localparam logic [3:0] CMD_USEKEY = 4'h6;
  // Return code classes
  localparam logic [1:0] RC_OK = 2'h0;
  localparam logic [1:0] RC_CRC = 2'h1;
  localparam logic [1:0] RC_RETRY = 2'h2;
  localparam logic [1:0] RC_ERR = 2'h3;
  // Reset values of the slot index and the key
  localparam logic [SLOT_W-1:0] SLOT_RST = 4'h0;
  localparam logic [KEY_W-1:0] KEY_RST = 256'h0;
  // Status word bit positions
  localparam int ST_SLOT_LSB = 0;
  localparam int ST_SRC = 4;
  localparam int ST_DIG = 5;
  localparam int ST_KGEN = 6;
  localparam int ST_NOMAC = 7;
  localparam int ST_VALID = 8;
endpackage

// File: core/eks_valid_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// Decides whether a finished command keeps or drops the validity flag
module eks_valid_ctl
  import eks_pkg::*;
(
  input wire logic [3:0] cmd,
  input wire logic [1:0] rc,
  input wire logic copy_ok,
  output logic keep_valid
);
  wire logic benign_rc;
  wire logic gen_keep;
  assign benign_rc = (rc == RC_CRC) || (rc == RC_RETRY);
  // Key writers keep the flag on success too
  assign gen_keep = benign_rc || (rc == RC_OK);
  assign keep_valid = (cmd == CMD_STATUS) ? 1'b1 :
                      (cmd == CMD_MACCHK) ? copy_ok :
                      (cmd == CMD_FRESH || cmd == CMD_DIGEST || cmd == CMD_KEYGEN) ? gen_keep :
                      benign_rc;
endmodule // eks_valid_ctl
`default_nettype wire

// File: verification/eks_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: hands the key register one finished command per call
module eks_host_model
  import eks_pkg::*;
(
  input wire logic clk,
  output logic cmd_done,
  output logic [3:0] cmd,
  output logic [1:0] rc,
  output logic copy_ok,
  output logic [KEY_W-1:0] new_key,
  output logic [SLOT_W-1:0] new_slot,
  output logic new_seed_only,
  output logic new_slot_nomac
);
  initial begin
    {cmd_done, cmd, rc, copy_ok, new_slot, new_seed_only, new_slot_nomac} = '0;
    new_key = KEY_RST;
  end
  // Data is only good with the pulse; key and slot inverted after so stale values cannot pass
  task automatic issue(input logic [3:0] c, input logic [1:0] r, input logic cp,
    input logic [KEY_W-1:0] k, input logic [SLOT_W-1:0] s, input logic sd, input logic nm);
    @(posedge clk) #10;
    {cmd, rc, copy_ok, new_key, new_slot, new_seed_only, new_slot_nomac} = {c, r, cp, k, s, sd, nm};
    cmd_done = 1'b1;
    @(posedge clk) #10;
    cmd_done = 1'b0;
    new_key = ~k;
    new_slot = ~s;
  endtask
endmodule // eks_host_model
`default_nettype wire

// File: verification/test_eks_key_reg.sv
`timescale 1ns/1ps
`default_nettype none
module test_eks_key_reg
  import eks_pkg::*;
;
  logic clk, rst, cmd_done, copy_ok, seed, nomac, idle, req, mac, grant, rej;
  logic [3:0] cmd, wipe;
  logic [1:0] rc;
  logic [KEY_W-1:0] nkey, ckey;
  logic [SLOT_W-1:0] slot;
  logic [FLAGS_W-1:0] st;
  int fails = 0;
  int num_checks = 0;
  eks_host_model eks_host_model_i (.clk(clk), .cmd_done(cmd_done), .cmd(cmd), .rc(rc),
    .copy_ok(copy_ok), .new_key(nkey), .new_slot(slot), .new_seed_only(seed),
    .new_slot_nomac(nomac));
  eks_key_reg eks_key_reg_i (.clk(clk), .rst(rst), .sleep_entry(wipe[0]), .brownout(wipe[1]),
    .watchdog(wipe[2]), .tamper(wipe[3]), .idle_mode(idle), .cmd_done(cmd_done), .cmd(cmd),
    .rc(rc), .copy_ok(copy_ok), .new_key(nkey), .new_slot(slot), .new_seed_only(seed),
    .new_slot_nomac(nomac), .use_req(req), .use_mac(mac), .use_grant(grant),
    .use_reject(rej), .crypt_key(ckey), .status_flags(st));
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [KEY_W-1:0] e, input logic [KEY_W-1:0] a);
    num_checks++;
    if (a !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, a);
    end
  endtask
  // Status word {valid, nomac, kgen, dig, src, slot}
  function automatic logic [KEY_W-1:0] fl(input logic [4:0] b, input logic [3:0] s);
    return {b, s};
  endfunction
  // Key use is combinational, so look within the request cycle
  task automatic use_key(input logic m, input logic g, input logic [KEY_W-1:0] k);
    @(posedge clk) #10;
    req = 1'b1;
    mac = m;
    #1 chk("grant", g, grant);
    chk("reject", !g, rej);
    chk("crypt_key", k, ckey);
    @(posedge clk) #10;
    req = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 60 cycles
  initial begin
    #(100 * 3000);
    fails++;
    complete_run();
  end
  initial begin
    {rst, idle, req, mac, wipe} = '1;
    {idle, req, mac, wipe} = '0;
    repeat (16) @(posedge clk);
    #10 rst = 1'b0;
    chk("flags", 0, st);
    eks_host_model_i.issue(CMD_FRESH, RC_OK, 0, 256'hA5, 4'h9, 1, 0);
    chk("flags", fl(5'h11, 0), st);
    use_key(0, 1, 256'hA5);
    idle = 1'b1;
    repeat (3) @(posedge clk);
    #10 idle = 1'b0;
    chk("flags", fl(5'h11, 0), st);
    eks_host_model_i.issue(CMD_DIGEST, RC_OK, 0, 256'h3C, 4'h5, 0, 1);
    chk("flags", fl(5'h1A, 5), st);
    use_key(1, 0, 0);
    use_key(0, 1, 256'h3C);
    eks_host_model_i.issue(CMD_STATUS, RC_ERR, 0, 256'h1, 4'h1, 0, 0);
    chk("flags", fl(5'h1A, 5), st);
    eks_host_model_i.issue(CMD_KEYGEN, RC_OK, 0, 256'h7E, 4'hF, 0, 0);
    chk("flags", fl(5'h1C, 4'hF), st);
    eks_host_model_i.issue(CMD_KEYGEN, RC_CRC, 0, 256'h2, 4'h2, 0, 0);
    chk("valid", 1, st[ST_VALID]);
    eks_host_model_i.issue(CMD_KEYGEN, RC_ERR, 0, 256'h2, 4'h2, 0, 0);
    chk("valid", 0, st[ST_VALID]);
    use_key(0, 0, 0);
    eks_host_model_i.issue(CMD_MACCHK, RC_OK, 1, 256'hC3, 4'h3, 0, 0);
    chk("valid", 1, st[ST_VALID]);
    eks_host_model_i.issue(CMD_MACCHK, RC_OK, 0, 256'hC3, 4'h3, 0, 0);
    chk("valid", 0, st[ST_VALID]);
    eks_host_model_i.issue(CMD_FRESH, RC_OK, 0, 256'h5A, 4'h0, 1, 0);
    eks_host_model_i.issue(CMD_USEKEY, RC_RETRY, 0, 256'h0, 4'h0, 0, 0);
    chk("valid", 1, st[ST_VALID]);
    eks_host_model_i.issue(CMD_USEKEY, RC_OK, 0, 256'h0, 4'h0, 0, 0);
    chk("valid", 0, st[ST_VALID]);
    // Tamper, watchdog, brownout keep metadata; sleep wipes all
    for (int i = 3; i >= 0; i--) begin
      eks_host_model_i.issue(CMD_FRESH, RC_OK, 0, 256'h5A, 4'h0, 1, 0);
      wipe = 4'h1 << i;
      @(posedge clk) #10 wipe = 4'h0;
      chk("flags", (i == 0) ? 0 : fl(5'h01, 0), st);
    end
    complete_run();
  end
endmodule // test_eks_key_reg
`default_nettype wire
